// ===== eirp_defines.svh
// Summary of operation
// - Reset pin input; open-drain low on failures
// - Reset sets non-maskable mask until cleared
// - Non-maskable input sensed by level only
// - Option bit picks level or falling edge
// - Maskable input level-sensitive after every presetn reset
// - Line still low re-interrupts when unmasked
// - Five peripheral pins also raise interrupts
// - Captures detect rising, falling or both
// - Accumulator and strobe: rising or falling
// - Strobe only single-chip; expanded drives address strobe
// - Peripheral interrupts gated locally and globally
// - Readable flags; clear pending without service
`ifndef EIRP_DEFINES_SVH
`define EIRP_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define EIRP_OFF_CTRL 8'h00
`define EIRP_OFF_EDGE 8'h04
`define EIRP_OFF_STATUS 8'h08
`define EIRP_OFF_MASK 8'h0C
`define EIRP_OFF_CCR 8'h10
`define EIRP_OFF_PINS 8'h14

// ==========================================================
// Field positions
`define EIRP_CTRL_EDGE_MODE 0
`define EIRP_CTRL_EXPANDED 1
`define EIRP_EDGE_PA_RISE 6
`define EIRP_EDGE_STRB_RISE 7
`define EIRP_ST_PA 3
`define EIRP_ST_STRB 4
`define EIRP_ST_CLKFAIL 5
`define EIRP_ST_WDFAIL 6
`define EIRP_CCR_I 0
`define EIRP_CCR_X 1
`define EIRP_PINS_PEND 8

// ==========================================================
// Reset values
`define EIRP_CTRL_RST 2'h0
`define EIRP_EDGE_RST 8'h00
`define EIRP_STATUS_RST 7'h00
`define EIRP_MASK_RST 7'h00
`define EIRP_CCR_RST 2'h3
`define EIRP_PINS_IDLE 8'hFF

// ==========================================================
// Timing
`define EIRP_CLK_PERIOD_NS 10
`define EIRP_RST_PULSE_NS 1000
`define EIRP_RST_PULSE_CYC \
   ((`EIRP_RST_PULSE_NS + `EIRP_CLK_PERIOD_NS - 1) / `EIRP_CLK_PERIOD_NS)

`endif

// ===== eirp_pkg.sv
package eirp_pkg;

   // Synchronised pin levels, one bit each
   typedef struct packed {
      logic strobe;
      logic pa;
      logic [2:0] cap;
      logic irq_n;
      logic nonmaskable_irq_in_n;
      logic rst_n;
   } eirp_pins_t;

   typedef enum logic [1:0] {
      EIRP_EDGE_OFF = 2'b00,
      EIRP_EDGE_RISE = 2'b01,
      EIRP_EDGE_FALL = 2'b10,
      EIRP_EDGE_ANY = 2'b11
   } eirp_edge_t;

   typedef enum logic [1:0] {
      EIRP_RD_IDLE = 2'b00,
      EIRP_RD_DRIVE = 2'b01,
      EIRP_RD_RELEASE = 2'b10
   } eirp_rdrv_t;

endpackage : eirp_pkg

// ===== eirp_pin_sync.sv
`timescale 1ns/1ps
module eirp_pin_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] IDLE = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw pins
   input wire logic [W-1:0] din,
   // Synchronised level and edge pulses
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   // ==========================================================
   // Two-stage synchroniser; only sync_r reads meta_r
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= IDLE;
         sync_r <= IDLE;
         prev_r <= IDLE;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign lvl = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule : eirp_pin_sync

// ===== eirp_top.sv
`timescale 1ns/1ps
`include "eirp_defines.svh"
module eirp_top #(
   parameter int RST_PULSE_CYC = `EIRP_RST_PULSE_CYC
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset pin, open drain
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic core_reset_n,
   // Failure detectors, same clock, one-cycle pulses
   input wire logic clock_mon_fail,
   input wire logic watchdog_timer_fail,
   // Interrupt and peripheral pins
   input wire logic nonmaskable_irq_in,
   input wire logic irq_n_in,
   input wire logic capture_in_1,
   input wire logic capture_in_2,
   input wire logic capture_in_3,
   input wire logic pulse_accum_in,
   input wire logic handshake_strobe_in,
   // Address strobe, shares the strobe pin
   input wire logic bus_addr_strobe,
   output logic addr_strobe_out,
   output logic addr_strobe_oe,
   // CPU side
   input wire logic cpu_irq_ack,
   output logic nmi_req,
   output logic irq_req,
   output logic periph_irq
);

   // ==========================================================
   // Pin synchronisation
   eirp_pkg::eirp_pins_t pin_raw;
   eirp_pkg::eirp_pins_t pin_lvl;
   eirp_pkg::eirp_pins_t pin_rise;
   eirp_pkg::eirp_pins_t pin_fall;

   assign pin_raw = {handshake_strobe_in, pulse_accum_in, capture_in_3,
                     capture_in_2, capture_in_1, irq_n_in,
                     nonmaskable_irq_in, reset_pin_in};

   eirp_pin_sync #(
      .W(8),
      .IDLE(`EIRP_PINS_IDLE)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(pin_raw),
      .lvl(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ==========================================================
   // Registers
   logic [1:0] ctrl_r;
   logic [7:0] edge_r;
   logic [6:0] status_r;
   logic [6:0] status_nxt;
   logic [6:0] mask_r;
   logic [1:0] ccr_r;
   logic irq_pend_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;

   logic acc;
   logic done;
   logic wr_done;
   logic rd_done;
   logic [31:0] rd_mux;
   logic [6:0] ev_set;
   logic [2:0] cap_hit;
   logic expanded;
   logic edge_mode;
   logic i_mask;
   logic x_mask;

   assign expanded = ctrl_r[`EIRP_CTRL_EXPANDED];
   assign edge_mode = ctrl_r[`EIRP_CTRL_EDGE_MODE];
   assign i_mask = ccr_r[`EIRP_CCR_I];
   assign x_mask = ccr_r[`EIRP_CCR_X];

   // ==========================================================
   // Helpers
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r,
                                     input logic f);
      logic hit;
      hit = 1'b0;
      case (eirp_pkg::eirp_edge_t'(sel))
         eirp_pkg::EIRP_EDGE_RISE: hit = r;
         eirp_pkg::EIRP_EDGE_FALL: hit = f;
         eirp_pkg::EIRP_EDGE_ANY: hit = r | f;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   function automatic logic addr_ok(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      if (a == `EIRP_OFF_CTRL) begin
         ok = 1'b1;
      end else if (a == `EIRP_OFF_EDGE) begin
         ok = 1'b1;
      end else if (a == `EIRP_OFF_STATUS) begin
         ok = 1'b1;
      end else if (a == `EIRP_OFF_MASK) begin
         ok = 1'b1;
      end else if (a == `EIRP_OFF_CCR) begin
         ok = 1'b1;
      end else if (a == `EIRP_OFF_PINS) begin
         ok = 1'b1;
      end
      return ok;
   endfunction : addr_ok

   // ==========================================================
   // APB handshake: one wait state, answer registered
   assign acc = psel & penable;
   assign done = acc & pready_r;
   assign wr_done = done & pwrite & addr_ok(paddr);
   assign rd_done = done & ~pwrite;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == `EIRP_OFF_CTRL) begin
         rd_mux = {30'h0000_0000, ctrl_r};
      end else if (paddr == `EIRP_OFF_EDGE) begin
         rd_mux = {24'h00_0000, edge_r};
      end else if (paddr == `EIRP_OFF_STATUS) begin
         rd_mux = {25'h000_0000, status_r};
      end else if (paddr == `EIRP_OFF_MASK) begin
         rd_mux = {25'h000_0000, mask_r};
      end else if (paddr == `EIRP_OFF_CCR) begin
         rd_mux = {30'h0000_0000, ccr_r};
      end else if (paddr == `EIRP_OFF_PINS) begin
         rd_mux = {23'h00_0000, irq_pend_r, pin_lvl};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc & ~pready_r;
         if (acc & ~pready_r) begin
            pslverr_r <= ~addr_ok(paddr);
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
         end else begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   // ==========================================================
   // Control and edge selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `EIRP_CTRL_RST;
         edge_r <= `EIRP_EDGE_RST;
         mask_r <= `EIRP_MASK_RST;
      end else if (wr_done) begin
         if (paddr == `EIRP_OFF_CTRL) begin
            ctrl_r <= pwdata[1:0];
         end else if (paddr == `EIRP_OFF_EDGE) begin
            edge_r <= pwdata[7:0];
         end else if (paddr == `EIRP_OFF_MASK) begin
            mask_r <= pwdata[6:0];
         end
      end
   end

   // ==========================================================
   // Global masks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccr_r <= `EIRP_CCR_RST;
      end else begin
         if (wr_done && paddr == `EIRP_OFF_CCR) begin
            ccr_r[`EIRP_CCR_I] <= pwdata[`EIRP_CCR_I];
            ccr_r[`EIRP_CCR_X] <= x_mask & pwdata[`EIRP_CCR_X];
         end
         // Taking a request masks further ones; X write is not lost
         if (cpu_irq_ack) begin
            ccr_r[`EIRP_CCR_I] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Peripheral pin events
   // capture edge choice
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cap
         assign cap_hit[gi] = edge_hit(edge_r[2*gi+1 -: 2],
                                       pin_rise.cap[gi], pin_fall.cap[gi]);
      end
   endgenerate

   always_comb begin
      ev_set = 7'h00;
      ev_set[2:0] = cap_hit;
      ev_set[`EIRP_ST_PA] = edge_hit(
         edge_r[`EIRP_EDGE_PA_RISE] ? eirp_pkg::EIRP_EDGE_RISE :
                                      eirp_pkg::EIRP_EDGE_FALL,
         pin_rise.pa, pin_fall.pa);
      ev_set[`EIRP_ST_STRB] = ~expanded & edge_hit(
         edge_r[`EIRP_EDGE_STRB_RISE] ? eirp_pkg::EIRP_EDGE_RISE :
                                        eirp_pkg::EIRP_EDGE_FALL,
         pin_rise.strobe, pin_fall.strobe);
      ev_set[`EIRP_ST_CLKFAIL] = clock_mon_fail;
      ev_set[`EIRP_ST_WDFAIL] = watchdog_timer_fail;
   end

   // read clears, new event wins
   // Only bits returned are cleared: a flag set in the wait state was
   // not in the captured word and must survive the read.
   assign status_nxt = (rd_done && paddr == `EIRP_OFF_STATUS) ?
                       ((status_r & ~prdata_r[6:0]) | ev_set) :
                       (status_r | ev_set);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= `EIRP_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ==========================================================
   // Maskable input edge latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pend_r <= 1'b0;
      end else if (edge_mode && pin_fall.irq_n) begin
         irq_pend_r <= 1'b1;
      end else if (cpu_irq_ack || !edge_mode) begin
         irq_pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // Requests to the CPU
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_req <= 1'b0;
         irq_req <= 1'b0;
         periph_irq <= 1'b0;
      end else begin
         nmi_req <= ~x_mask & ~pin_lvl.nonmaskable_irq_in_n;
         irq_req <= ~i_mask & (edge_mode ? irq_pend_r : ~pin_lvl.irq_n);
         periph_irq <= ~i_mask & (|(status_nxt & mask_r));
      end
   end

   // ==========================================================
   // Address strobe takes the strobe pin in expanded mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_strobe_out <= 1'b0;
         addr_strobe_oe <= 1'b0;
      end else begin
         addr_strobe_oe <= expanded;
         addr_strobe_out <= expanded & bus_addr_strobe;
      end
   end

   // ==========================================================
   // Reset pin driver
   // The release state waits for the pin to read high again, so a
   // stuck-low pin does not retrigger the pulse forever.
   eirp_pkg::eirp_rdrv_t rd_state_r;
   logic [$clog2(RST_PULSE_CYC+1)-1:0] rd_cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_state_r <= eirp_pkg::EIRP_RD_IDLE;
         rd_cnt_r <= '0;
         reset_pin_oe <= 1'b0;
      end else begin
         case (rd_state_r)
            eirp_pkg::EIRP_RD_IDLE: begin
               if (clock_mon_fail || watchdog_timer_fail) begin
                  rd_state_r <= eirp_pkg::EIRP_RD_DRIVE;
                  rd_cnt_r <= ($bits(rd_cnt_r))'(RST_PULSE_CYC - 1);
                  reset_pin_oe <= 1'b1;
               end
            end
            eirp_pkg::EIRP_RD_DRIVE: begin
               if (rd_cnt_r == '0) begin
                  rd_state_r <= eirp_pkg::EIRP_RD_RELEASE;
                  reset_pin_oe <= 1'b0;
               end else begin
                  rd_cnt_r <= rd_cnt_r - 1'b1;
               end
            end
            eirp_pkg::EIRP_RD_RELEASE: begin
               if (pin_lvl.rst_n) begin
                  rd_state_r <= eirp_pkg::EIRP_RD_IDLE;
               end
            end
            default: begin
               rd_state_r <= eirp_pkg::EIRP_RD_IDLE;
               reset_pin_oe <= 1'b0;
            end
         endcase
      end
   end

   // Open drain: only ever drives low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_pin_out <= 1'b0;
         core_reset_n <= 1'b0;
      end else begin
         reset_pin_out <= 1'b0;
         // pin low holds the core in reset
         core_reset_n <= pin_lvl.rst_n;
      end
   end

endmodule : eirp_top

// ===== eirp_top_monitor.sv
`timescale 1ns/1ps
// ==========
// Port checker
module eirp_top_monitor #(
   parameter int RST_PULSE_CYC = 100
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Reset pin and failures
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic clock_mon_fail,
   input wire logic watchdog_timer_fail,
   // Interrupts
   input wire logic nonmaskable_irq_in,
   input wire logic irq_n_in,
   input wire logic cpu_irq_ack,
   input wire logic nmi_req,
   input wire logic irq_req,
   // Address strobe
   input wire logic addr_strobe_out,
   input wire logic addr_strobe_oe
);
   logic [15:0] oe_cnt_r;
   logic x_clr_r;
   logic edge_r;
   logic wr_ok;
   assign wr_ok = psel & penable & pready & pwrite;
   // Software view of X and sensing mode, tracked from committed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_cnt_r <= 16'h0;
         x_clr_r <= 1'b0;
         edge_r <= 1'b0;
      end else begin
         oe_cnt_r <= reset_pin_oe ? oe_cnt_r + 16'h1 : 16'h0;
         if (wr_ok && paddr == 8'h10 && !pwdata[1]) begin
            x_clr_r <= 1'b1;
         end
         if (wr_ok && paddr == 8'h00) begin
            edge_r <= pwdata[0];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_od_low; reset_pin_out == 1'b0; endproperty
   a_od_low: assert property (p_od_low)
      else $error("reset pin data not low");
   property p_oe_cause;
      $rose(reset_pin_oe) |-> $past(clock_mon_fail || watchdog_timer_fail);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("reset pin pulled without failure");
   property p_oe_len; $fell(reset_pin_oe) |-> oe_cnt_r == RST_PULSE_CYC; endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("reset pin pulse length wrong");
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait)
      else $error("more than one wait state");
   property p_nmi_mask; !x_clr_r |-> !nmi_req; endproperty
   a_nmi_mask: assert property (p_nmi_mask)
      else $error("nonmaskable request while masked");
   property p_nmi_lvl;
      nmi_req |-> $past(!nonmaskable_irq_in, 3) || $past(!nonmaskable_irq_in, 4);
   endproperty
   a_nmi_lvl: assert property (p_nmi_lvl)
      else $error("nonmaskable request without low level");
   property p_irq_lvl;
      !edge_r && $past(!edge_r, 3) && irq_req |->
         $past(!irq_n_in, 3) || $past(!irq_n_in, 4);
   endproperty
   a_irq_lvl: assert property (p_irq_lvl)
      else $error("level mode request without low level");
   property p_ack; cpu_irq_ack |-> ##2 !irq_req; endproperty
   a_ack: assert property (p_ack)
      else $error("request stands after acknowledge");
   property p_as; addr_strobe_out |-> addr_strobe_oe; endproperty
   a_as: assert property (p_as)
      else $error("address strobe outside expanded mode");
endmodule : eirp_top_monitor
bind eirp_top eirp_top_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_mon (.*);

// ===== eirp_partner.sv
`timescale 1ns/1ps
// ==========
// Far side: interrupt sources and reset supervisor
module eirp_partner (
   // Clock and acknowledge
   input wire logic pclk,
   input wire logic cpu_irq_ack,
   // Bench commands
   input wire logic [1:0] raise,
   input wire logic glitch,
   input wire logic nmi_on,
   input wire logic supv_low,
   // Device reset driver
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   // Wired lines, pulled up
   output logic irq_n_in,
   output logic nonmaskable_irq_in,
   output logic reset_pin_in
);
   logic [1:0] src_r = 2'b00;
   logic [1:0] gl_r = 2'b00;
   always_ff @(posedge pclk) begin
      // One acknowledge releases only the lowest source
      src_r <= (cpu_irq_ack ? src_r & (src_r - 2'h1) : src_r) | raise;
      gl_r <= glitch ? 2'h3 : gl_r - {1'b0, |gl_r};
   end
   assign irq_n_in = ~((|src_r) | (|gl_r));
   assign nonmaskable_irq_in = ~nmi_on;
   assign reset_pin_in = ~(supv_low | (reset_pin_oe & ~reset_pin_out));
endmodule : eirp_partner

// ===== eirp_top_tb.sv
`timescale 1ns/1ps
// ==========
// Bench top
module eirp_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, core_reset_n;
   logic clock_mon_fail, watchdog_timer_fail, cpu_irq_ack, err;
   logic nonmaskable_irq_in, irq_n_in, nmi_req, irq_req, periph_irq;
   logic bus_addr_strobe, addr_strobe_out, addr_strobe_oe;
   logic [4:0] pins, old, h, msk;
   logic [7:0] cfg;
   logic [1:0] raise;
   logic glitch, nmi_on, supv_low;
   int n_errors = 0;
   int num_checks = 0;
   wire capture_in_1 = pins[0];
   wire capture_in_2 = pins[1];
   wire capture_in_3 = pins[2];
   wire pulse_accum_in = pins[3];
   wire handshake_strobe_in = pins[4];
   eirp_top #(.RST_PULSE_CYC(4)) DUT (.*);
   eirp_partner u_far (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #100us;
      n_errors++;
      stop_test();
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      cyc(1);
      penable <= 1'b1;
      // Waits for pready; only the watchdog ends a wait that never sees it
      do begin
         cyc(1);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(1);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdc
   task automatic ack();
      cpu_irq_ack <= 1'b1;
      cyc(1);
      cpu_irq_ack <= 1'b0;
      cyc(3);
   endtask : ack
   // Expected flags for one pin change under a given edge setup
   function automatic logic [4:0] model(input logic [4:0] o, n,
                                        input logic [7:0] c, input logic x);
      logic [4:0] r, f, s;
      r = ~o & n;
      f = o & ~n;
      for (int i = 0; i < 3; i++) s[i] = (r[i] & c[2*i]) | (f[i] & c[2*i+1]);
      s[3] = c[6] ? r[3] : f[3];
      s[4] = !x && (c[7] ? r[4] : f[4]);
      return s;
   endfunction : model
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {clock_mon_fail, watchdog_timer_fail, cpu_irq_ack} = '0;
      {bus_addr_strobe, raise, glitch, nmi_on, supv_low} = '0;
      pins = 5'h1F;
      presetn = 1'b0;
      void'($urandom(32'hAB9475B3));
      cyc(3);
      presetn <= 1'b1;
      cyc(1);
      for (int i = 0; i < 2; i++) begin
         clock_mon_fail <= (i == 0);
         watchdog_timer_fail <= (i == 1);
         cyc(1);
         clock_mon_fail <= 1'b0;
         watchdog_timer_fail <= 1'b0;
         cyc(1);
         chk("oe", 1, reset_pin_oe);
         cyc(3);
         chk("core_rst", 0, core_reset_n);
         cyc(10);
         chk("oe_end", 0, reset_pin_oe);
      end
      supv_low <= 1'b1;
      cyc(5);
      chk("supv", 0, core_reset_n);
      supv_low <= 1'b0;
      cyc(5);
      rdc(8'h10, 32'h3, "ccr");
      rdc(8'h00, 32'h0, "ctrl");
      apb(1'b0, 8'h1C, 32'h0);
      chk("slverr", 1, err);
      chk("unmapped", 0, rd);
      nmi_on <= 1'b1;
      cyc(6);
      chk("nmi_masked", 0, nmi_req);
      apb(1'b1, 8'h10, 32'h2);
      rdc(8'h10, 32'h2, "x_stuck");
      apb(1'b1, 8'h10, 32'h1);
      cyc(4);
      chk("nmi", 1, nmi_req);
      nmi_on <= 1'b0;
      cyc(6);
      chk("nmi_off", 0, nmi_req);
      raise <= 2'b11;
      cyc(1);
      raise <= 2'b00;
      apb(1'b1, 8'h10, 32'h0);
      cyc(3);
      chk("irq", 1, irq_req);
      ack();
      chk("irq_acked", 0, irq_req);
      apb(1'b1, 8'h10, 32'h0);
      cyc(3);
      chk("irq_again", 1, irq_req);
      ack();
      apb(1'b1, 8'h10, 32'h0);
      cyc(3);
      chk("irq_idle", 0, irq_req);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h10, 32'h1);
      glitch <= 1'b1;
      cyc(1);
      glitch <= 1'b0;
      cyc(8);
      rdc(8'h14, 32'h1FF, "pend");
      apb(1'b1, 8'h10, 32'h0);
      cyc(3);
      chk("irq_edge", 1, irq_req);
      ack();
      rdc(8'h14, 32'hFF, "pend_clr");
      apb(1'b1, 8'h00, 32'h0);
      for (int t = 0; t < 16; t++) begin
         cfg = 8'($urandom);
         msk = 5'($urandom);
         apb(1'b1, 8'h00, {30'h0, t[0], 1'b0});
         apb(1'b1, 8'h04, {24'h0, cfg});
         apb(1'b1, 8'h0C, {27'h0, msk});
         apb(1'b1, 8'h10, {31'h0, t[1]});
         apb(1'b0, 8'h08, 32'h0);
         old = pins;
         pins <= 5'($urandom);
         cyc(1);
         h = model(old, pins, cfg, t[0]);
         cyc(5);
         chk("periph", !t[1] && |(h & msk), periph_irq);
         rdc(8'h08, {27'h0, h}, "status");
      end
      rdc(8'h08, 32'h0, "st_clr");
      chk("periph_clr", 0, periph_irq);
      apb(1'b1, 8'h00, 32'h2);
      bus_addr_strobe <= 1'b1;
      cyc(3);
      chk("as_out", 1, addr_strobe_out);
      chk("as_oe", 1, addr_strobe_oe);
      bus_addr_strobe <= 1'b0;
      apb(1'b1, 8'h00, 32'h0);
      cyc(2);
      chk("as_oe_off", 0, addr_strobe_oe);
      stop_test();
   end
endmodule : eirp_top_tb
